// >>> rtl/bbt_defines.vh
// constants for the boot buffer transfer handshake
`ifndef BBT_DEFINES_VH
`define BBT_DEFINES_VH

// host select codes
`define BBT_SEL_STATUS      2'h0
`define BBT_SEL_BOOT_CTL    2'h1
`define BBT_SEL_BUFFER      2'h2

// shared_transfer_status fields
`define BBT_READY_BIT       0
`define BBT_DONE_BIT        1
`define BBT_STATUS_RESET    2'h0

// boot_control_register fields
`define BBT_HOLD_BIT        0
`define BBT_HOLD_RESET      1'h1

// shared ram layout, in words
`define BBT_RAM_WORDS       256
`define BBT_BUF_BASE        8'h80
// words after the header slot, the largest part one session can carry
`define BBT_BUF_ROOM        8'h7f
`define BBT_ADDR_W          8

`endif

// >>> rtl/bbt_handshake.v
// device side of the boot buffer transfer handshake with copy engine
`timescale 1ns/100ps
`include "bbt_defines.vh"

module bbt_handshake #(
    parameter DATA_W  = 32,                 // shared ram word width
    parameter IRAM_AW = 16                  // internal ram address width
) (
    input  wire                 clk,             // 200 MHz clock
    input  wire                 rst_n,           // synchronous reset, active low
    input  wire [1:0]           host_sel,        // host register select
    input  wire [`BBT_ADDR_W-1:0] host_addr,     // shared ram word address
    input  wire                 host_wr,         // host write strobe
    input  wire                 host_rd,         // host read strobe
    input  wire [DATA_W-1:0]    host_wdata,      // host write data
    output reg  [DATA_W-1:0]    host_rdata,      // host read data
    output reg                  loader_run,      // loader released from hold
    output reg                  exec_start,      // program execution begins
    output reg                  iram_valid,      // word ready for internal ram
    input  wire                 iram_ready,      // internal ram accepts word
    output reg  [IRAM_AW-1:0]   iram_addr,       // internal ram word address
    output reg  [DATA_W-1:0]    iram_data        // internal ram word data
);

    localparam ST_HOLD  = 7'h01;
    localparam ST_HAND  = 7'h02;
    localparam ST_WAIT  = 7'h04;
    localparam ST_HDR   = 7'h08;
    localparam ST_COPY  = 7'h10;
    localparam ST_DRAIN = 7'h20;
    localparam ST_RUN   = 7'h40;

    localparam [`BBT_ADDR_W-1:0] BUF_ROOM = `BBT_BUF_ROOM;

    reg [DATA_W-1:0]      shared_ram [0:`BBT_RAM_WORDS-1];
    reg                   buffer_ready_flag;
    reg                   transfer_done_flag;
    reg                   boot_hold_bit;
    reg [6:0]             state;
    reg [6:0]             next_state;
    reg                   exec_state;
    reg [`BBT_ADDR_W-1:0] rd_ptr;
    reg [`BBT_ADDR_W-1:0] words_left;
    reg [IRAM_AW-1:0]     dest;
    reg [1:0]             cnt;
    reg [1:0]             next_cnt;
    reg [IRAM_AW-1:0]     slot1_addr;
    reg [DATA_W-1:0]      slot1_data;

    wire [DATA_W-1:0] rd_word  = shared_ram[rd_ptr];
    wire              push     = (state == ST_COPY) && (cnt != 2'h2) && (words_left != 0);
    wire              pop      = iram_valid && iram_ready;
    wire              st_write = host_wr && (host_sel == `BBT_SEL_STATUS);
    wire [`BBT_ADDR_W-1:0] hdr_words =
        (rd_word[`BBT_ADDR_W-1:0] > BUF_ROOM) ? BUF_ROOM : rd_word[`BBT_ADDR_W-1:0];

    // host side of the shared ram
    always @(posedge clk) begin
        // buffer writes refused while device owns it
        if (host_wr && host_sel == `BBT_SEL_BUFFER &&
            (buffer_ready_flag || host_addr < `BBT_BUF_BASE))
            shared_ram[host_addr] <= host_wdata;
    end

    // status and boot control registers
    always @(posedge clk) begin
        if (!rst_n) begin
            buffer_ready_flag  <= 1'b0;
            transfer_done_flag <= 1'b0;
            boot_hold_bit      <= `BBT_HOLD_RESET;
        end else begin
            // device raises ready; set wins over a host clear
            if (state == ST_HAND)
                buffer_ready_flag <= 1'b1;
            // host clears ready when its part is written
            else if (st_write)
                buffer_ready_flag <= host_wdata[`BBT_READY_BIT];
            // done flag is the host's alone
            if (st_write)
                transfer_done_flag <= host_wdata[`BBT_DONE_BIT];
            if (host_wr && host_sel == `BBT_SEL_BOOT_CTL)
                boot_hold_bit <= host_wdata[`BBT_HOLD_BIT];
        end
    end

    // host read port
    always @(posedge clk) begin
        if (!rst_n)
            host_rdata <= {DATA_W{1'b0}};
        else if (host_rd) begin
            host_rdata <= {DATA_W{1'b0}};
            case (host_sel)
                // done in bit 1, ready in bit 0
                `BBT_SEL_STATUS: begin
                    host_rdata[`BBT_DONE_BIT]  <= transfer_done_flag;
                    host_rdata[`BBT_READY_BIT] <= buffer_ready_flag;
                end
                `BBT_SEL_BOOT_CTL: begin
                    host_rdata[`BBT_HOLD_BIT] <= boot_hold_bit;
                end
                `BBT_SEL_BUFFER: begin
                    host_rdata <= shared_ram[host_addr];
                end
                default: begin
                    host_rdata <= {DATA_W{1'b0}};
                end
            endcase
        end
    end

    // session sequencer
    always @* begin
        next_state = state;
        case (state)
            ST_HOLD: begin
                // clearing the hold starts the loader
                if (!boot_hold_bit)
                    next_state = ST_HAND;
            end
            ST_HAND: begin
                next_state = ST_WAIT;
            end
            ST_WAIT: begin
                // copy only once host returns buffer
                // ready 0 with done 1 means execute
                if (!buffer_ready_flag && transfer_done_flag)
                    next_state = ST_RUN;
                else if (!buffer_ready_flag)
                    next_state = ST_HDR;
            end
            ST_HDR: begin
                next_state = ST_COPY;
            end
            ST_COPY: begin
                if (words_left == 0)
                    next_state = ST_DRAIN;
            end
            ST_DRAIN: begin
                // ready only after every word left
                if (cnt == 2'h0)
                    next_state = ST_HAND;
            end
            ST_RUN: begin
                next_state = ST_RUN;
            end
            default: begin
                next_state = ST_HOLD;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            state      <= ST_HOLD;
            exec_state <= 1'b0;
            rd_ptr     <= `BBT_BUF_BASE;
            words_left <= {`BBT_ADDR_W{1'b0}};
            dest       <= {IRAM_AW{1'b0}};
            loader_run <= 1'b0;
            exec_start <= 1'b0;
        end else begin
            state      <= next_state;
            loader_run <= !boot_hold_bit || loader_run;
            exec_start <= 1'b0;
            if (state == ST_WAIT && next_state == ST_RUN && !exec_state) begin
                exec_state <= 1'b1;
                exec_start <= 1'b1;
            end
            // header sits at the buffer base above the loader
            if (state == ST_HAND)
                rd_ptr <= `BBT_BUF_BASE;
            if (state == ST_HDR) begin
                // size taken from the part's header
                words_left <= hdr_words;
                rd_ptr     <= `BBT_BUF_BASE + 1'b1;
            end
            if (push) begin
                words_left <= words_left - 1'b1;
                rd_ptr     <= rd_ptr + 1'b1;
                dest       <= dest + 1'b1;
            end
        end
    end

    // two-entry buffer toward internal ram; slot 0 drives the outputs
    always @* begin
        next_cnt = cnt;
        if (push && !pop)
            next_cnt = cnt + 2'h1;
        else if (pop && !push)
            next_cnt = cnt - 2'h1;
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            cnt        <= 2'h0;
            iram_valid <= 1'b0;
            iram_addr  <= {IRAM_AW{1'b0}};
            iram_data  <= {DATA_W{1'b0}};
            slot1_addr <= {IRAM_AW{1'b0}};
            slot1_data <= {DATA_W{1'b0}};
        end else begin
            cnt        <= next_cnt;
            iram_valid <= (next_cnt != 2'h0);
            if (pop && cnt == 2'h2) begin
                iram_addr <= slot1_addr;
                iram_data <= slot1_data;
            end else if (push && (cnt == 2'h0 || (cnt == 2'h1 && pop))) begin
                iram_addr <= dest;
                iram_data <= rd_word;
            end else if (push && cnt == 2'h1) begin
                slot1_addr <= dest;
                slot1_data <= rd_word;
            end
        end
    end

endmodule

// >>> test/bbt_handshake_assertions.sv
// assertions for the boot buffer handshake ports
`timescale 1ns/100ps
module bbt_checker #(
    parameter DATA_W  = 32,
    parameter IRAM_AW = 16
) (
    input wire               clk,        // clock
    input wire               rst_n,      // reset, active low
    input wire [1:0]         host_sel,   // register select
    input wire [7:0]         host_addr,  // ram address
    input wire               host_wr,    // write strobe
    input wire               host_rd,    // read strobe
    input wire [DATA_W-1:0]  host_wdata, // write data
    input wire [DATA_W-1:0]  host_rdata, // read data
    input wire               loader_run, // loader released
    input wire               exec_start, // execution pulse
    input wire               iram_valid, // word offered
    input wire               iram_ready, // word accepted
    input wire [IRAM_AW-1:0] iram_addr,  // word address
    input wire [DATA_W-1:0]  iram_data   // word data
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    reset_clear_a:
        assert property (disable iff (1'b0) !rst_n |=> !loader_run && !exec_start
            && !iram_valid && host_rdata == 0) else $error("outputs not cleared by reset");
    stall_hold_a:
        assert property (iram_valid && !iram_ready |=> iram_valid && $stable(iram_addr)
            && $stable(iram_data)) else $error("stalled word changed");
    addr_step_a:
        assert property (iram_valid && iram_ready ##1 iram_valid |->
            iram_addr == $past(iram_addr) + 1) else $error("ram address not ascending");
    exec_once_a:
        assert property (exec_start |=> !exec_start [*8]) else $error("execution repeated");
    exec_idle_a:
        assert property (exec_start |-> loader_run && !iram_valid) else $error("early exec");
    run_sticks_a:
        assert property (loader_run |=> loader_run) else $error("loader dropped");
    run_start_a:
        assert property (host_wr && host_sel == 2'h1 && !host_wdata[0] |-> ##2 loader_run)
            else $error("loader not started");
    spare_zero_a:
        assert property (host_rd && host_sel == 2'h0 |=> host_rdata[31:2] == 0)
            else $error("spare status bits set");
    copy_after_run_a:
        assert property (iram_valid |-> loader_run) else $error("copy before loader");
    cover property (exec_start);
    cover property (iram_valid && !iram_ready);
    cover property ($rose(loader_run));
endmodule
bind bbt_handshake bbt_checker #(.DATA_W(DATA_W), .IRAM_AW(IRAM_AW)) chk (.clk(clk),
    .rst_n(rst_n), .host_sel(host_sel), .host_addr(host_addr), .host_wr(host_wr),
    .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .loader_run(loader_run), .exec_start(exec_start), .iram_valid(iram_valid),
    .iram_ready(iram_ready), .iram_addr(iram_addr), .iram_data(iram_data));

// >>> test/bbt_iram_model.sv
// internal ram sink that records copied words
`timescale 1ns/100ps
module bbt_iram_model (
    input  wire        clk,        // clock
    input  wire        rst_n,      // reset, active low
    input  wire        stall,      // throttle acceptance
    input  wire        iram_valid, // word offered
    output reg         iram_ready, // word accepted
    input  wire [15:0] iram_addr,  // word address
    input  wire [31:0] iram_data   // word data
);
    reg [31:0] mem [0:15];
    integer    taken;
    always @(posedge clk) begin
        if (!rst_n) begin
            iram_ready <= 1'b0;
            taken <= 0;
        end else begin
            // every other cycle refused so the buffer fills
            iram_ready <= stall ? ~iram_ready : 1'b1;
            if (iram_valid && iram_ready) begin
                mem[iram_addr[3:0]] <= iram_data;
                taken <= taken + 1;
            end
        end
    end
endmodule

// >>> test/testbench.sv
// self-checking bench for the boot buffer handshake
`timescale 1ns/100ps
`include "bbt_defines.vh"
`define CHK(a, e) begin check_count = check_count + 1; if ((a) !== (e)) begin \
    errors = errors + 1; $display("Error at %0t: got %h expected %h", $time, a, e); end end
module testbench;
    reg         clk = 1'b0;
    reg         rst_n = 1'b0;
    reg  [1:0]  host_sel = 2'h3;
    reg  [7:0]  host_addr = 8'h00;
    reg         host_wr = 1'b0;
    reg         host_rd = 1'b0;
    reg  [31:0] host_wdata = 32'h0;
    reg         stall = 1'b0;
    reg  [31:0] rdv;
    wire [31:0] host_rdata;
    wire [31:0] iram_data;
    wire [15:0] iram_addr;
    wire        loader_run, exec_start, iram_valid, iram_ready;
    integer     errors = 0, check_count = 0, k, seen;
    bbt_handshake DUT (.clk(clk), .rst_n(rst_n), .host_sel(host_sel), .host_addr(host_addr),
        .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .loader_run(loader_run), .exec_start(exec_start),
        .iram_valid(iram_valid), .iram_ready(iram_ready), .iram_addr(iram_addr),
        .iram_data(iram_data));
    bbt_iram_model model (.clk(clk), .rst_n(rst_n), .stall(stall), .iram_valid(iram_valid),
        .iram_ready(iram_ready), .iram_addr(iram_addr), .iram_data(iram_data));
    initial forever #2.5 clk = ~clk;
    task test_done;
        begin
            $display("checks %0d errors %0d", check_count, errors);
            if (errors == 0 && check_count > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    task wr(input [1:0] s, input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            host_sel <= s;
            host_addr <= a;
            host_wdata <= d;
            host_wr <= 1'b1;
            @(posedge clk);
            host_wr <= 1'b0;
        end
    endtask
    task rd(input [1:0] s, input [7:0] a);
        begin
            @(posedge clk);
            host_sel <= s;
            host_addr <= a;
            host_rd <= 1'b1;
            @(posedge clk);
            host_rd <= 1'b0;
            #1 rdv = host_rdata;
        end
    endtask
    task wait_ready;
        begin
            rdv = 0;
            for (k = 0; k < 100 && rdv[0] !== 1'b1; k = k + 1)
                rd(`BBT_SEL_STATUS, 8'h00);
        end
    endtask
    task session(input [31:0] n, input [31:0] base);
        begin
            wr(`BBT_SEL_BUFFER, `BBT_BUF_BASE, n);
            for (k = 1; k <= n; k = k + 1)
                wr(`BBT_SEL_BUFFER, `BBT_BUF_BASE + k[7:0], base + k);
            wr(`BBT_SEL_STATUS, 8'h00, 32'h0);
        end
    endtask
    initial begin
        #20000;
        errors = errors + 1;
        test_done;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd(`BBT_SEL_STATUS, 8'h00);
        `CHK(rdv, 32'h0)
        rd(`BBT_SEL_BOOT_CTL, 8'h00);
        `CHK(rdv[0], `BBT_HOLD_RESET)
        wr(`BBT_SEL_BOOT_CTL, 8'h00, 32'h0);
        wait_ready;
        `CHK(loader_run, 1'b1)
        `CHK(rdv, 32'h1)
        stall <= 1'b1;
        session(3, 32'h1000);
        rd(`BBT_SEL_STATUS, 8'h00);
        `CHK(rdv[0], 1'b0)
        // loader area stays writable while the device owns the buffer
        wr(`BBT_SEL_BUFFER, 8'h10, 32'h0000_5a5a);
        wr(`BBT_SEL_BUFFER, 8'h81, 32'hdead_beef);
        rd(`BBT_SEL_BUFFER, 8'h81);
        `CHK(rdv, 32'h1001)
        rd(`BBT_SEL_BUFFER, 8'h10);
        `CHK(rdv, 32'h0000_5a5a)
        wait_ready;
        `CHK(model.taken, 3)
        `CHK(model.mem[2], 32'h1003)
        stall <= 1'b0;
        session(2, 32'h2000);
        wait_ready;
        `CHK(model.mem[4], 32'h2002)
        `CHK(model.taken, 5)
        `CHK(exec_start, 1'b0)
        wr(`BBT_SEL_STATUS, 8'h00, 32'h2);
        seen = 0;
        for (k = 0; k < 8; k = k + 1) begin
            @(posedge clk);
            #1 if (exec_start === 1'b1) seen = seen + 1;
        end
        `CHK(seen, 1)
        rd(`BBT_SEL_STATUS, 8'h00);
        `CHK(rdv, 32'h2)
        `CHK(rdv[1], 1'b1)
        test_done;
    end
endmodule
